// ===== hdl/asrc_pkg.sv
package asrc_pkg;
    // Sample word and servo arithmetic widths
    localparam int SAMPLE_W      = 24;
    localparam int FRAC_W        = 20;
    localparam int STEP_W        = 24;
    localparam int PER_W         = 16;
    localparam int GAIN_W        = 9;

    // Clock and accuracy figures
    localparam int SYS_PERIOD_PS = 8000;
    localparam int FINE_ERR_PS   = 5;
    localparam int JITTER_CORNER_HZ = 1;

    // Phase step reset value: one input sample per output sample
    localparam logic [STEP_W-1:0] STEP_RST = 24'h100000;

    // Servo loop gains (shift counts) and settle thresholds
    localparam int FAST_SHIFT    = 6;
    localparam int SLOW_SHIFT    = 14;
    localparam logic [27:0] FAST_TOL = 28'h0040000;
    localparam logic [27:0] FINE_TOL = 28'h0000100;
    localparam logic [15:0] SETTLE_CNT = 16'h0040;
    localparam logic [PER_W-1:0] RATE_TOL = 16'h0008;

    // FIFO fill target and soft mute ramp
    localparam int FIFO_DEPTH    = 8;
    localparam logic [3:0] FILL_TARGET = 4'h4;
    localparam logic [GAIN_W-1:0] GAIN_FULL = 9'h100;
    localparam logic [GAIN_W-1:0] GAIN_STEP = 9'h004;
    localparam int GAIN_SHIFT    = 8;

    typedef enum logic [0:0] {
        ASRC_FAST,
        ASRC_SLOW
    } asrc_servo_e;
endpackage

// ===== hdl/asrc_fifo.sv
`timescale 1ns/1ps
module asrc_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic                       clk_in,
    input  wire logic                       rst_in,
    // Fill side
    input  wire logic                       in_valid_in,
    input  wire logic [WIDTH-1:0]           in_data_in,
    output logic                            in_ready_out,
    // Drain side
    output logic                            out_valid_out,
    output logic [WIDTH-1:0]                out_data_out,
    input  wire logic                       out_ready_in,
    // Fill level
    output logic [$clog2(DEPTH+1)-1:0]      level_out
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [LW-1:0]    cnt_q;
    logic             push;
    logic             pop;

    assign in_ready_out  = (cnt_q != LW'(DEPTH));
    assign out_valid_out = (cnt_q != '0);
    assign out_data_out  = mem_q[rd_q];
    assign level_out     = cnt_q;
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + LW'(push) - LW'(pop);
        end
    end
endmodule

// ===== hdl/asrc_link.sv
`timescale 1ns/1ps
module asrc_link #(
    parameter int WIDTH = 24
) (
    // Link clock and reset
    input  wire logic               link_clk_in,
    input  wire logic               rst_in,
    // Serial pins
    input  wire logic               serial_in_line,
    input  wire logic               in_frame_in,
    input  wire logic               out_frame_in,
    output logic                    serial_out_line,
    // Words to and from the system domain
    input  wire logic [WIDTH-1:0]   out_word_in,
    output logic [WIDTH-1:0]        in_word_out,
    output logic                    in_tgl_out,
    output logic                    out_tgl_out
);
    localparam int CW = $clog2(WIDTH+1);

    logic [WIDTH-1:0] in_sh_q;
    logic [WIDTH-1:0] out_sh_q;
    logic [CW-1:0]    in_cnt_q;
    logic [1:0]       rst_s_q;
    logic             link_rst;

    // Reset asserts at once, releases on the link clock
    always_ff @(posedge link_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rst_s_q <= 2'b11;
        end else begin
            rst_s_q <= {rst_s_q[0], 1'b0};
        end
    end

    assign link_rst = rst_s_q[1];

    // Input word assembly, MSB first; word held until next word completes
    always_ff @(posedge link_clk_in or posedge link_rst) begin
        if (link_rst) begin
            in_sh_q     <= '0;
            in_cnt_q    <= '0;
            in_word_out <= '0;
            in_tgl_out  <= 1'b0;
        end else if (in_frame_in) begin
            in_sh_q  <= {{(WIDTH-1){1'b0}}, serial_in_line};
            in_cnt_q <= CW'(1);
        end else if (in_cnt_q != '0) begin
            in_sh_q <= {in_sh_q[WIDTH-2:0], serial_in_line};
            if (in_cnt_q == CW'(WIDTH-1)) begin
                in_word_out <= {in_sh_q[WIDTH-2:0], serial_in_line};
                in_tgl_out  <= ~in_tgl_out;
                in_cnt_q    <= '0;
            end else begin
                in_cnt_q <= in_cnt_q + 1'b1;
            end
        end
    end

    // Output word shifting; each frame start asks for the next word
    always_ff @(posedge link_clk_in or posedge link_rst) begin
        if (link_rst) begin
            out_sh_q        <= '0;
            serial_out_line <= 1'b0;
            out_tgl_out     <= 1'b0;
        end else if (out_frame_in) begin
            serial_out_line <= out_word_in[WIDTH-1];
            out_sh_q        <= {out_word_in[WIDTH-2:0], 1'b0};
            out_tgl_out     <= ~out_tgl_out;
        end else begin
            serial_out_line <= out_sh_q[WIDTH-1];
            out_sh_q        <= {out_sh_q[WIDTH-2:0], 1'b0};
        end
    end
endmodule

// ===== hdl/asrc_core.sv
`timescale 1ns/1ps
module asrc_core
    import asrc_pkg::*;
#(
    parameter int WIDTH = SAMPLE_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // System clock and reset
    input  wire logic               clk_in,
    input  wire logic               sys_rst_in,
    // Link clock and serial pins
    input  wire logic               link_clk_in,
    input  wire logic               serial_in_line,
    input  wire logic               in_frame_in,
    input  wire logic               out_frame_in,
    output logic                    serial_out_line,
    // Control pins
    input  wire logic               reset_n_in,
    input  wire logic               bypass_in,
    input  wire logic               mute_in,
    // Status pins
    output logic                    mute_out,
    output logic                    locked_out,
    output logic                    fifo_ready_out
);
    localparam int LW = $clog2(DEPTH+1);

    function automatic logic [PER_W-1:0] abs_diff(input logic [PER_W-1:0] a,
                                                  input logic [PER_W-1:0] b);
        abs_diff = (a > b) ? a - b : b - a;
    endfunction

    function automatic logic [27:0] abs28(input logic signed [27:0] v);
        abs28 = v[27] ? 28'(-v) : 28'(v);
    endfunction

    // Link side
    logic [WIDTH-1:0] link_word;
    logic             link_in_tgl;
    logic             link_out_tgl;
    logic [WIDTH-1:0] out_word_q;

    asrc_link #(.WIDTH(WIDTH)) u_link (
        .link_clk_in     (link_clk_in),
        .rst_in          (sys_rst_in),
        .serial_in_line  (serial_in_line),
        .in_frame_in     (in_frame_in),
        .out_frame_in    (out_frame_in),
        .serial_out_line (serial_out_line),
        .out_word_in     (out_word_q),
        .in_word_out     (link_word),
        .in_tgl_out      (link_in_tgl),
        .out_tgl_out     (link_out_tgl)
    );

    // Synchronisers for pins and link toggles
    logic [2:0] in_tgl_s_q;
    logic [2:0] out_tgl_s_q;
    logic [1:0] rstn_s_q;
    logic [1:0] byp_s_q;
    logic [1:0] mute_s_q;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            in_tgl_s_q  <= '0;
            out_tgl_s_q <= '0;
            rstn_s_q    <= '0;
            byp_s_q     <= '0;
            mute_s_q    <= '0;
        end else begin
            in_tgl_s_q  <= {in_tgl_s_q[1:0], link_in_tgl};
            out_tgl_s_q <= {out_tgl_s_q[1:0], link_out_tgl};
            rstn_s_q    <= {rstn_s_q[0], reset_n_in};
            byp_s_q     <= {byp_s_q[0], bypass_in};
            mute_s_q    <= {mute_s_q[0], mute_in};
        end
    end

    logic dev_rst;
    logic in_evt;
    logic out_evt;
    logic bypass;

    assign dev_rst = ~rstn_s_q[1];
    assign in_evt  = in_tgl_s_q[2] ^ in_tgl_s_q[1];
    assign out_evt = out_tgl_s_q[2] ^ out_tgl_s_q[1];
    assign bypass  = byp_s_q[1];

    // Input word buffer
    logic             f_ready;
    logic             f_valid;
    logic [WIDTH-1:0] f_data;
    logic             f_pop;
    logic [LW-1:0]    f_level;

    asrc_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
        .clk_in        (clk_in),
        .rst_in        (sys_rst_in),
        .in_valid_in   (in_evt && !dev_rst),
        .in_data_in    (link_word),
        .in_ready_out  (f_ready),
        .out_valid_out (f_valid),
        .out_data_out  (f_data),
        .out_ready_in  (f_pop),
        .level_out     (f_level)
    );

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            fifo_ready_out <= 1'b0;
        end else begin
            fifo_ready_out <= f_ready;
        end
    end

    // Sample period measurement for rate change detection
    logic [PER_W-1:0] in_cnt_q;
    logic [PER_W-1:0] in_per_q;
    logic [PER_W-1:0] out_cnt_q;
    logic [PER_W-1:0] out_per_q;
    logic             rate_chg;

    assign rate_chg = (in_evt && in_per_q != '0 && abs_diff(in_cnt_q, in_per_q) > RATE_TOL)
                   || (out_evt && out_per_q != '0
                       && abs_diff(out_cnt_q, out_per_q) > RATE_TOL);

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            in_cnt_q  <= '0;
            in_per_q  <= '0;
            out_cnt_q <= '0;
            out_per_q <= '0;
        end else if (dev_rst) begin
            in_cnt_q  <= '0;
            in_per_q  <= '0;
            out_cnt_q <= '0;
            out_per_q <= '0;
        end else begin
            in_cnt_q  <= in_evt ? '0 : in_cnt_q + PER_W'(in_cnt_q != '1);
            out_cnt_q <= out_evt ? '0 : out_cnt_q + PER_W'(out_cnt_q != '1);
            if (in_evt) begin
                in_per_q <= in_cnt_q;
            end
            if (out_evt) begin
                out_per_q <= out_cnt_q;
            end
        end
    end

    // Phase accumulator: integer part pops inputs, fraction sets the linear interpolation point
    logic [FRAC_W-1:0]       frac_q;
    logic [STEP_W-1:0]       step_q;
    logic [3:0]              pend_q;
    logic [STEP_W:0]         phase_sum;
    logic signed [7:0]       net_fill;
    logic signed [27:0]      fill_err;
    logic signed [27:0]      step_adj;
    logic signed [27:0]      prop_adj;
    logic [STEP_W-1:0]       rate;
    asrc_servo_e             state_q;

    assign phase_sum = {1'b0, {(STEP_W-FRAC_W){1'b0}}, frac_q} + {1'b0, rate};
    assign net_fill  = $signed({4'h0, 4'(f_level)}) - $signed({4'h0, pend_q})
                     - $signed({4'h0, FILL_TARGET});
    assign fill_err  = $signed({net_fill, FRAC_W'(0)}) - $signed({8'h00, frac_q});
    assign step_adj  = (state_q == ASRC_FAST) ? (fill_err >>> FAST_SHIFT)
                                              : (fill_err >>> SLOW_SHIFT);
    // Proportional term damps the loop; without it the servo rings
    assign prop_adj  = (state_q == ASRC_FAST) ? (fill_err >>> (FAST_SHIFT / 2))
                                              : (fill_err >>> (SLOW_SHIFT / 2));
    assign rate      = step_q + STEP_W'(prop_adj);
    assign f_pop     = bypass ? (out_evt && f_valid) : (pend_q != '0 && f_valid);

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            frac_q <= '0;
            step_q <= STEP_RST;
            pend_q <= '0;
        end else if (dev_rst || bypass) begin
            frac_q <= '0;
            step_q <= STEP_RST;
            pend_q <= '0;
        end else begin
            pend_q <= pend_q - 4'(f_pop)
                    + (out_evt ? 4'(phase_sum[STEP_W:FRAC_W]) : 4'h0);
            if (out_evt) begin
                frac_q <= phase_sum[FRAC_W-1:0];
                step_q <= step_q + STEP_W'(step_adj);
            end
        end
    end

    // Servo mode: fast after reset or rate change, slow once settled
    logic [15:0] settle_q;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q    <= ASRC_FAST;
            settle_q   <= '0;
            locked_out <= 1'b0;
        end else if (dev_rst || rate_chg) begin
            state_q    <= ASRC_FAST;
            settle_q   <= '0;
            locked_out <= 1'b0;
        end else if (out_evt && !bypass) begin
            case (state_q)
                ASRC_FAST: begin
                    locked_out <= 1'b0;
                    if (abs28(fill_err) < FAST_TOL) begin
                        if (settle_q == SETTLE_CNT - 1'b1) begin
                            state_q  <= ASRC_SLOW;
                            settle_q <= '0;
                        end else begin
                            settle_q <= settle_q + 1'b1;
                        end
                    end else begin
                        settle_q <= '0;
                    end
                end
                ASRC_SLOW: begin
                    locked_out <= (abs28(fill_err) < FINE_TOL);
                end
                default: begin
                    state_q <= ASRC_FAST;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mute_out <= 1'b1;
        end else begin
            mute_out <= (state_q == ASRC_FAST);
        end
    end

    // Sample history for interpolation
    logic signed [WIDTH-1:0] prev_q;
    logic signed [WIDTH-1:0] cur_q;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prev_q <= '0;
            cur_q  <= '0;
        end else if (dev_rst) begin
            prev_q <= '0;
            cur_q  <= '0;
        end else if (f_pop && !bypass) begin
            prev_q <= cur_q;
            cur_q  <= f_data;
        end
    end

    // Soft mute gain ramp, one step per output sample
    logic [GAIN_W-1:0] gain_q;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            gain_q <= '0;
        end else if (dev_rst) begin
            gain_q <= '0;
        end else if (out_evt) begin
            if (mute_s_q[1]) begin
                gain_q <= (gain_q > GAIN_STEP) ? gain_q - GAIN_STEP : '0;
            end else begin
                gain_q <= (gain_q < GAIN_FULL - GAIN_STEP) ? gain_q + GAIN_STEP
                                                           : GAIN_FULL;
            end
        end
    end

    // Output word: interpolated and scaled, or raw in bypass
    logic signed [WIDTH:0]          diff;
    logic signed [WIDTH+FRAC_W+1:0] prod;
    logic signed [WIDTH-1:0]        interp;
    logic signed [WIDTH+GAIN_W:0]   scaled;

    assign diff   = $signed({cur_q[WIDTH-1], cur_q}) - $signed({prev_q[WIDTH-1], prev_q});
    assign prod   = diff * $signed({1'b0, frac_q});
    assign interp = prev_q + WIDTH'(prod >>> FRAC_W);
    assign scaled = interp * $signed({1'b0, gain_q});

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            out_word_q <= '0;
        end else if (dev_rst) begin
            out_word_q <= '0;
        end else if (out_evt) begin
            if (bypass) begin
                out_word_q <= f_valid ? f_data : out_word_q;
            end else begin
                out_word_q <= WIDTH'(scaled >>> GAIN_SHIFT);
            end
        end
    end
endmodule

// ===== dv/asrc_core_monitor.sv
`timescale 1ns/1ps
module asrc_core_monitor
    import asrc_pkg::*;
#(
    parameter int WIDTH = SAMPLE_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic   clk_in,
    input  wire logic   sys_rst_in,
    // Control pins
    input  wire logic   reset_n_in,
    input  wire logic   mute_in,
    input  wire logic   bypass_in,
    // Status pins
    input  wire logic   mute_out,
    input  wire logic   locked_out,
    input  wire logic   fifo_ready_out
);
    a_hold_mute: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !reset_n_in [*5] |-> mute_out) else $error("mute flag low in device reset");
    a_hold_unlock: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !reset_n_in [*5] |-> !locked_out) else $error("lock flag high in device reset");
    a_lock_slow_only: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        locked_out |-> !mute_out) else $error("lock flag high in fast mode");
    a_release_fast: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $rose(reset_n_in) |-> mute_out [*8]) else $error("fast mode not held after release");
    a_drop_fast: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $fell(reset_n_in) |-> ##[1:4] mute_out) else $error("fast mode not entered on reset");
    a_drop_unlock: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $fell(reset_n_in) |-> ##[1:4] !locked_out) else $error("lock kept through reset");
    a_exit_needs_run: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $fell(mute_out) |-> reset_n_in && $past(reset_n_in, 3))
        else $error("fast mode left while held in reset");
    a_sys_reset_state: assert property (@(posedge clk_in)
        sys_rst_in |-> mute_out && !locked_out && !fifo_ready_out)
        else $error("wrong status during system reset");
    c_settled: cover property (@(posedge clk_in) disable iff (sys_rst_in) $fell(mute_out));
    c_locked: cover property (@(posedge clk_in) disable iff (sys_rst_in) $rose(locked_out));
    c_bypass: cover property (@(posedge clk_in) disable iff (sys_rst_in) bypass_in && !mute_out);
    c_soft_mute: cover property (@(posedge clk_in) disable iff (sys_rst_in) $rose(mute_in));
endmodule
bind asrc_core asrc_core_monitor #(.WIDTH(WIDTH), .DEPTH(DEPTH)) asrc_core_monitor_inst (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reset_n_in(reset_n_in), .mute_in(mute_in),
    .bypass_in(bypass_in), .mute_out(mute_out), .locked_out(locked_out),
    .fifo_ready_out(fifo_ready_out));

// ===== dv/asrc_audio_peer.sv
`timescale 1ns/1ps
module asrc_audio_peer (
    // Link clock and test controls
    input  wire logic           link_clk_in,
    input  wire logic           stream_in,
    input  wire logic           ramp_in,
    input  wire logic           slow_in_in,
    input  wire logic [23:0]    src_word_in,
    // Serial pins
    input  wire logic           serial_out_line,
    output logic                serial_in_line,
    output logic                in_frame_in,
    output logic                out_frame_in,
    // Captured output words
    output logic [23:0]         got_word_out,
    output logic                got_tgl_out
);
    logic [4:0]  icnt_q;
    logic [4:0]  ocnt_q;
    logic [7:0]  idx_q;
    logic [23:0] shin_q;
    logic [23:0] shout_q;
    logic [23:0] next_w;
    assign next_w = src_word_in + (ramp_in ? {16'h0, idx_q} : 24'h0);
    initial begin
        {icnt_q, ocnt_q, idx_q, shin_q, shout_q, got_word_out} = '0;
        {serial_in_line, in_frame_in, out_frame_in, got_tgl_out} = '0;
    end
    // Source: MSB first, idle line toggles; equal periods unless slowed
    always @(posedge link_clk_in) begin
        if (!stream_in) begin
            icnt_q <= 5'h0;
            in_frame_in <= 1'b0;
            serial_in_line <= ~serial_in_line;
        end else begin
            icnt_q <= (icnt_q == (slow_in_in ? 5'h1d : 5'h19)) ? 5'h0 : icnt_q + 5'h1;
            in_frame_in <= (icnt_q == 5'h0);
            if (icnt_q == 5'h0) begin
                serial_in_line <= next_w[23];
                shin_q <= {next_w[22:0], 1'b0};
                idx_q <= idx_q + 8'h1;
            end else if (icnt_q < 5'h18) begin
                serial_in_line <= shin_q[23];
                shin_q <= {shin_q[22:0], 1'b0};
            end else begin
                serial_in_line <= ~serial_in_line;
            end
        end
    end
    // Sink: frame, then 24 bits MSB first
    always @(posedge link_clk_in) begin
        if (!stream_in) begin
            ocnt_q <= 5'h0;
            out_frame_in <= 1'b0;
        end else begin
            ocnt_q <= (ocnt_q == 5'h19) ? 5'h0 : ocnt_q + 5'h1;
            out_frame_in <= (ocnt_q == 5'h0);
            if (ocnt_q >= 5'h2) begin
                shout_q <= {shout_q[22:0], serial_out_line};
            end
            if (ocnt_q == 5'h19) begin
                got_word_out <= {shout_q[22:0], serial_out_line};
                got_tgl_out <= ~got_tgl_out;
            end
        end
    end
endmodule

// ===== dv/asrc_core_tb_top.sv
`timescale 1ns/1ps
module asrc_core_tb_top;
    import asrc_pkg::*;
    logic clk_in, link_clk_in, sys_rst_in, reset_n_in, bypass_in, mute_in;
    logic serial_in_line, in_frame_in, out_frame_in, serial_out_line;
    logic mute_out, locked_out, fifo_ready_out;
    logic stream, ramp, slow_in, got_tgl;
    logic [23:0] src_word, got_word, w, prev;
    int errors = 0;
    int cmp_count = 0;
    int n;
    asrc_core asrc_core_inst (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .link_clk_in(link_clk_in),
        .serial_in_line(serial_in_line), .in_frame_in(in_frame_in),
        .out_frame_in(out_frame_in), .serial_out_line(serial_out_line),
        .reset_n_in(reset_n_in), .bypass_in(bypass_in), .mute_in(mute_in),
        .mute_out(mute_out), .locked_out(locked_out), .fifo_ready_out(fifo_ready_out));
    asrc_audio_peer asrc_audio_peer_inst (
        .link_clk_in(link_clk_in), .stream_in(stream), .ramp_in(ramp), .slow_in_in(slow_in),
        .src_word_in(src_word), .serial_out_line(serial_out_line),
        .serial_in_line(serial_in_line), .in_frame_in(in_frame_in),
        .out_frame_in(out_frame_in), .got_word_out(got_word), .got_tgl_out(got_tgl));
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    initial begin
        link_clk_in = 1'b0;
        #3;
        forever #24 link_clk_in = ~link_clk_in;
    end
    task automatic check_bit(input string name, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic check_word(input string name, input logic [23:0] exp, input logic [23:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Wait for the next word captured at the serial output
    task automatic get_word(output logic [23:0] wd);
        logic t;
        int k;
        t = got_tgl;
        k = 0;
        while (got_tgl === t && k < 2000) begin
            @(posedge clk_in);
            k++;
        end
        if (k >= 2000) errors++;
        wd = got_word;
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #800000;
        errors++;
        tally_and_finish();
    end
    initial begin
        sys_rst_in = 1'b1;
        {reset_n_in, bypass_in, mute_in, stream, ramp, slow_in} = '0;
        src_word = 24'h0;
        repeat (5) @(posedge clk_in);
        check_bit("mute_out", 1'b1, mute_out);
        check_bit("locked_out", 1'b0, locked_out);
        sys_rst_in <= 1'b0;
        repeat (10) @(posedge clk_in);
        check_bit("mute_out", 1'b1, mute_out);
        reset_n_in <= 1'b1;
        bypass_in <= 1'b1;
        ramp <= 1'b1;
        src_word <= 24'ha5c300;
        stream <= 1'b1;
        repeat (12) get_word(w);
        for (int i = 0; i < 8; i++) begin
            prev = w;
            get_word(w);
            check_word("bypass_word", prev + 24'h1, w);
            check_word("bypass_high", 24'ha5c300, {w[23:8], 8'h0});
        end
        bypass_in <= 1'b0;
        ramp <= 1'b0;
        src_word <= 24'h200000;
        reset_n_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        check_bit("mute_out", 1'b1, mute_out);
        reset_n_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        check_bit("mute_out", 1'b1, mute_out);
        n = 0;
        while (mute_out !== 1'b0 && n < 400) begin
            get_word(w);
            n++;
        end
        check_bit("mute_out", 1'b0, mute_out);
        check_bit("fifo_ready_out", 1'b1, fifo_ready_out);
        repeat (70) get_word(w);
        check_word("full_level", 24'h200000, w);
        mute_in <= 1'b1;
        repeat (3) get_word(w);
        check_bit("ramp_down", 1'b1, (w != 24'h0) && (w < 24'h200000));
        repeat (80) get_word(w);
        check_word("muted", 24'h0, w);
        mute_in <= 1'b0;
        repeat (3) get_word(w);
        check_bit("ramp_up", 1'b1, (w != 24'h0) && (w < 24'h080000));
        slow_in <= 1'b1;
        n = 0;
        while (mute_out !== 1'b1 && n < 20) begin
            get_word(w);
            n++;
        end
        check_bit("mute_out", 1'b1, mute_out);
        tally_and_finish();
    end
endmodule
